// File: case_dec_pkg.sv
// Shared constants, formats and carrier types for the case matcher and value decoder
package case_dec_pkg;

	// ==========================================================
	// Bus widths
	localparam int DATA_W = 8;
	localparam int VAL_W = 32;
	localparam int DEC_FRAC_W = 2;
	localparam int DEC_INT_W = DATA_W - DEC_FRAC_W;

	// ==========================================================
	// Number formats
	typedef enum logic [2:0]
	{
		FMT_SINT = 3'h1,
		FMT_SFRAC = 3'h2,
		FMT_UINT = 3'h4
	} fmt_t;

	// ==========================================================
	// Case table: one slot per listed case, up to three alternatives each
	localparam int NUM_SLOTS = 5;
	localparam int MAX_ALTS = 3;
	localparam int CASE_VAL [0:NUM_SLOTS-1][0:MAX_ALTS-1] = '{
		'{1, 2, 3},
		'{4, 0, 0},
		'{4, 6, 0},
		'{7, 0, 0},
		'{0, 0, 0}
	};
	// Alternatives in use per slot; an empty slot stands for a trailing separator
	localparam logic [MAX_ALTS-1:0] CASE_ALT_EN [0:NUM_SLOTS-1] = '{
		3'h7,
		3'h1,
		3'h3,
		3'h1,
		3'h0
	};

	// Count of real cases, skipping empty slots
	function automatic int count_cases();
		int n;
		n = 0;
		for (int s = 0; s < NUM_SLOTS; s++)
		begin
			if (CASE_ALT_EN[s] != '0)
				n++;
		end
		return n;
	endfunction : count_cases

	localparam int NUM_CASES = count_cases();

	// Slot that holds the given case output
	function automatic int slot_of_case(input int c);
		int n;
		int r;
		n = 0;
		r = 0;
		for (int s = 0; s < NUM_SLOTS; s++)
		begin
			if (CASE_ALT_EN[s] != '0)
			begin
				if (n == c)
					r = s;
				n++;
			end
		end
		return r;
	endfunction : slot_of_case

	// ==========================================================
	// Reset values
	localparam logic RST_BIT = 1'h0;

	// ==========================================================
	// Carrier of the case matcher result
	typedef struct packed
	{
		logic [NUM_CASES-1:0] hit;
		logic others;
	} case_res_t;

endpackage : case_dec_pkg

// File: case_value_decoder.sv
// Multi-way case matcher with default output, and the single-value decoder
`timescale 1ns/1ns

// Function
// - One output per case, high on equality, only the earliest matching case
// - Compared bus is signed or unsigned integer
// - Trailing empty case is dropped, no output
// - Case output rises on any alternative
// - Default output high when no case high, only on an integer bus format
// - Pipeline option registers case outputs
// - Decoder output high on match, else low
// - Decoded value truncated to the bus width
// - Fraction bits only for signed fractional
// - Register option registers decoder match
// - Signed formats treat MSB as sign
// - Integer formats: width equals integer bits
module case_value_decoder
	import case_dec_pkg::*;
(
	input wire logic mclk_i,                         // System clock
	input wire logic rstn_i,                         // Synchronous reset, active low
	input wire logic [DATA_W-1:0] case_data_i,       // Case matcher input bus
	input wire fmt_t case_fmt_i,                     // Case matcher bus format
	input wire logic case_pipe_i,                    // Register the case outputs
	input wire logic case_dflt_en_i,                 // Enable the default output
	input wire logic [DATA_W-1:0] dec_data_i,        // Decoder input bus
	input wire fmt_t dec_fmt_i,                      // Decoder bus format
	input wire logic dec_reg_i,                      // Register the decoder output
	input wire logic signed [VAL_W-1:0] dec_value_i, // Decoded value
	output case_res_t case_res_o,                    // Case outputs and default output
	output logic case_any_o,                         // Some case output is high
	output logic case_fmt_err_o,                     // Unsupported format on case bus
	output logic dec_match_o                         // Decoder match
);

	// ==========================================================
	// Format helpers

	// True when a case value is representable in the bus format
	function automatic logic value_fits(input int v, input logic sgn);
		logic ok;
		if (sgn)
		begin
			ok = (v >= -(2 ** (DATA_W - 1))) && (v < (2 ** (DATA_W - 1)));
		end
		else
		begin
			ok = (v >= 0) && (v < (2 ** DATA_W));
		end
		return ok;
	endfunction : value_fits

	// Bus pattern of a case value
	function automatic logic [DATA_W-1:0] value_bits(input int v);
		logic [VAL_W-1:0] w;
		w = VAL_W'(v);
		return w[DATA_W-1:0];
	endfunction : value_bits

	// True when the bus equals any enabled alternative of a slot
	function automatic logic slot_match(
		input logic [DATA_W-1:0] d,
		input int s,
		input logic sgn
	);
		logic m;
		m = 1'h0;
		for (int a = 0; a < MAX_ALTS; a++)
		begin
			if (CASE_ALT_EN[s][a] && value_fits(CASE_VAL[s][a], sgn))
			begin
				if (d == value_bits(CASE_VAL[s][a]))
					m = 1'h1;
			end
		end
		return m;
	endfunction : slot_match

	// Keep only the lowest set bit: the earliest listed case wins
	function automatic logic [NUM_CASES-1:0] first_one(input logic [NUM_CASES-1:0] v);
		return v & (~v + NUM_CASES'(1));
	endfunction : first_one

	// ==========================================================
	// Case matcher decode
	wire logic case_signed;
	wire logic case_fmt_ok;
	logic [NUM_CASES-1:0] raw_hit;
	wire logic [NUM_CASES-1:0] hit_comb;
	wire logic others_comb;
	wire case_res_t res_comb;

	// Fractional formats are refused on the compared bus
	assign case_fmt_ok = (case_fmt_i == FMT_SINT) || (case_fmt_i == FMT_UINT);
	assign case_signed = (case_fmt_i == FMT_SINT);

	// Only non-empty slots map onto outputs
	always_comb
	begin
		raw_hit = '0;
		for (int c = 0; c < NUM_CASES; c++)
		begin
			raw_hit[c] = slot_match(case_data_i, slot_of_case(c), case_signed);
		end
	end

	assign hit_comb = case_fmt_ok ? first_one(raw_hit) : '0;
	assign others_comb = case_dflt_en_i && case_fmt_ok && (hit_comb == '0);
	assign res_comb = '{hit: hit_comb, others: others_comb};

	// ==========================================================
	// Case matcher pipeline register
	case_res_t res_ff;
	case_res_t nxt_res;

	assign nxt_res = rstn_i ? res_comb : '0;

	always_ff @(posedge mclk_i)
	begin
		res_ff <= nxt_res;
	end

	assign case_res_o = case_pipe_i ? res_ff : res_comb;

	// ==========================================================
	// Status outputs
	logic any_ff;
	logic fmt_err_ff;
	wire logic nxt_any;
	wire logic nxt_fmt_err;

	assign nxt_any = rstn_i ? (res_comb.hit != '0) : RST_BIT;
	assign nxt_fmt_err = rstn_i ? ~case_fmt_ok : RST_BIT;

	always_ff @(posedge mclk_i)
	begin
		any_ff <= nxt_any;
		fmt_err_ff <= nxt_fmt_err;
	end

	assign case_any_o = case_pipe_i ? any_ff : (res_comb.hit != '0);
	assign case_fmt_err_o = fmt_err_ff;

	// ==========================================================
	// Value decoder
	value_decoder u_value_decoder
	(
		.mclk_i(mclk_i),
		.rstn_i(rstn_i),
		.data_i(dec_data_i),
		.fmt_i(dec_fmt_i),
		.reg_en_i(dec_reg_i),
		.value_i(dec_value_i),
		.match_o(dec_match_o)
	);

endmodule : case_value_decoder

// File: cvd_checker.sv
// Port checks for the case matcher and value decoder
`timescale 1ns/1ns
module cvd_checker
	import case_dec_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rstn_i,
	input wire logic [DATA_W-1:0] case_data_i,
	input wire fmt_t case_fmt_i,
	input wire logic case_pipe_i,
	input wire logic case_dflt_en_i,
	input wire logic [DATA_W-1:0] dec_data_i,
	input wire fmt_t dec_fmt_i,
	input wire logic dec_reg_i,
	input wire logic signed [VAL_W-1:0] dec_value_i,
	input wire case_res_t case_res_o,
	input wire logic case_any_o,
	input wire logic case_fmt_err_o,
	input wire logic dec_match_o
);
	// ==========================================================
	// Assertions
	wire logic ok = case_fmt_i inside {FMT_SINT, FMT_UINT};
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	AST_ONEHOT:
	assert property ($onehot0(case_res_o)) else $error("case outputs overlap");
	AST_DFLT:
	assert property (!case_pipe_i && ok |-> case_res_o.others == (case_dflt_en_i && !case_any_o))
		else $error("default output wrong");
	AST_ALT:
	assert property (!case_pipe_i && ok && case_data_i inside {8'h01, 8'h02, 8'h03}
		|-> case_res_o.hit == 4'h1) else $error("alternative missed");
	AST_HIT:
	assert property (!case_pipe_i && ok && case_data_i == 8'h07 |-> case_res_o.hit == 4'h8)
		else $error("case output wrong");
	AST_PIPE:
	assert property (case_pipe_i && $past(rstn_i) && $past(ok) && $past(case_data_i) == 8'h06
		|-> case_res_o.hit == 4'h4) else $error("pipelined output wrong");
	AST_REFUSE:
	assert property (!ok && !case_pipe_i |-> case_res_o == '0) else $error("bad format matched");
	AST_ERR:
	assert property (!ok |=> case_fmt_err_o) else $error("format error missing");
	AST_DEC:
	assert property (!dec_reg_i && dec_fmt_i == FMT_UINT
		|-> dec_match_o == (dec_data_i == dec_value_i[7:0])) else $error("decoder wrong");
	AST_FRAC:
	assert property (!dec_reg_i && dec_fmt_i == FMT_SFRAC
		|-> dec_match_o == (dec_data_i == {dec_value_i[5:0], 2'h0})) else $error("fraction wrong");
	AST_DREG:
	assert property (dec_reg_i && $past(rstn_i) && $past(dec_fmt_i) == FMT_SINT
		|-> dec_match_o == ($past(dec_data_i) == 8'($past(dec_value_i))))
		else $error("registered match wrong");
endmodule : cvd_checker

bind case_value_decoder cvd_checker chk_u (.mclk_i, .rstn_i, .case_data_i, .case_fmt_i,
	.case_pipe_i, .case_dflt_en_i, .dec_data_i, .dec_fmt_i, .dec_reg_i, .dec_value_i,
	.case_res_o, .case_any_o, .case_fmt_err_o, .dec_match_o);

// File: tb.sv
// Self-checking bench for the case matcher and value decoder
`timescale 1ns/1ns
module tb;
	import case_dec_pkg::*;
	logic mclk_i, rstn_i, case_pipe_i, case_dflt_en_i, dec_reg_i;
	logic [DATA_W-1:0] case_data_i, dec_data_i;
	fmt_t case_fmt_i, dec_fmt_i;
	logic signed [VAL_W-1:0] dec_value_i;
	case_res_t case_res_o;
	logic case_any_o, case_fmt_err_o, dec_match_o;
	int mismatches, checks_done;
	fmt_t fl [3] = '{FMT_SINT, FMT_SFRAC, FMT_UINT};
	case_value_decoder dut_u (.mclk_i, .rstn_i, .case_data_i, .case_fmt_i, .case_pipe_i,
		.case_dflt_en_i, .dec_data_i, .dec_fmt_i, .dec_reg_i, .dec_value_i, .case_res_o,
		.case_any_o, .case_fmt_err_o, .dec_match_o);
	// ==========================================================
	// Expectations and compares
	function automatic case_res_t ec(logic [DATA_W-1:0] d, fmt_t f, logic de);
		case_res_t r;
		r.hit = d inside {8'h01, 8'h02, 8'h03} ? 4'h1 : d == 8'h04 ? 4'h2 :
			d == 8'h06 ? 4'h4 : d == 8'h07 ? 4'h8 : 4'h0;
		if (!(f inside {FMT_SINT, FMT_UINT}))
			r.hit = '0;
		r.others = de && (f inside {FMT_SINT, FMT_UINT}) && r.hit == '0;
		return r;
	endfunction : ec
	function automatic logic ed(logic [DATA_W-1:0] d, fmt_t f, logic signed [VAL_W-1:0] v);
		logic [VAL_W-1:0] w;
		w = (f == FMT_SFRAC) ? v <<< DEC_FRAC_W : v;
		return d == w[DATA_W-1:0];
	endfunction : ed
	task automatic cmp_res(case_res_t e);
		checks_done++;
		if ({case_res_o, case_any_o} !== {e, |e.hit})
		begin
			mismatches++;
			$display("Error case_res exp %h seen %h", {e, |e.hit}, {case_res_o, case_any_o});
		end
	endtask : cmp_res
	task automatic cmp_bit(string n, logic s, logic e);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("Error %s exp %b seen %b", n, e, s);
		end
	endtask : cmp_bit
	// Hold inputs one cycle: combinational outputs before the edge, registered ones after
	task automatic run();
		case_res_t ce;
		logic em;
		ce = ec(case_data_i, case_fmt_i, case_dflt_en_i);
		em = ed(dec_data_i, dec_fmt_i, dec_value_i);
		#5;
		if (!case_pipe_i) cmp_res(ce);
		if (!dec_reg_i) cmp_bit("dec_match", dec_match_o, em);
		@(posedge mclk_i);
		#1;
		if (case_pipe_i) cmp_res(ce);
		if (dec_reg_i) cmp_bit("dec_match", dec_match_o, em);
		cmp_bit("fmt_err", case_fmt_err_o, !(case_fmt_i inside {FMT_SINT, FMT_UINT}));
	endtask : run
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	// ==========================================================
	// Clock, watchdog, stimulus
	initial
	begin
		mclk_i = 1'h0;
		forever #10 mclk_i = ~mclk_i;
	end
	initial
	begin
		#60000;
		mismatches++;
		summarize();
	end
	initial
	begin
		{rstn_i, case_pipe_i, case_dflt_en_i, dec_reg_i} = 4'h0;
		{case_data_i, dec_data_i, dec_value_i} = '0;
		case_fmt_i = FMT_UINT;
		dec_fmt_i = FMT_UINT;
		void'($urandom(32'hc3cc2ac3));
		repeat (16) @(posedge mclk_i);
		#1 rstn_i = 1'h1;
		// Every case value, format and option, with truncation of 0x105 on the decoder
		for (int k = 0; k < 120; k++)
		begin
			case_fmt_i = fl[k / 40];
			case_data_i = 8'(k % 10);
			case_pipe_i = 1'((k / 10) % 2);
			case_dflt_en_i = 1'((k / 20) % 2);
			dec_value_i = 32'sh105;
			dec_data_i = 8'(k);
			dec_fmt_i = fl[k % 3];
			dec_reg_i = k[0];
			run();
		end
		// Mid-run reset clears every registered output, even with a matching input
		case_pipe_i = 1'h1;
		dec_reg_i = 1'h1;
		case_fmt_i = FMT_SFRAC;
		case_data_i = 8'h07;
		dec_fmt_i = FMT_UINT;
		dec_data_i = 8'h05;
		dec_value_i = 32'sh5;
		rstn_i = 1'h0;
		@(posedge mclk_i);
		#1;
		cmp_res('0);
		cmp_bit("dec_match", dec_match_o, 1'h0);
		cmp_bit("fmt_err", case_fmt_err_o, 1'h0);
		rstn_i = 1'h1;
		repeat (400)
		begin
			case_fmt_i = fl[$urandom_range(0, 2)];
			case_data_i = $urandom_range(0, 3) ? 8'($urandom_range(0, 9)) : 8'($urandom);
			{case_pipe_i, case_dflt_en_i, dec_reg_i} = 3'($urandom);
			dec_fmt_i = fl[$urandom_range(0, 2)];
			dec_value_i = $urandom_range(0, 600) - 300;
			dec_data_i = $urandom_range(0, 1) ? 8'($urandom) :
				8'(dec_fmt_i == FMT_SFRAC ? dec_value_i <<< 2 : dec_value_i);
			run();
		end
		summarize();
	end
endmodule : tb

// File: value_decoder.sv
// Single-value decoder with optional registered match output
`timescale 1ns/1ns
module value_decoder
	import case_dec_pkg::*;
(
	input wire logic mclk_i,                     // System clock
	input wire logic rstn_i,                     // Synchronous reset, active low
	input wire logic [DATA_W-1:0] data_i,        // Compared input bus
	input wire fmt_t fmt_i,                      // Input bus format
	input wire logic reg_en_i,                   // Register the match result
	input wire logic signed [VAL_W-1:0] value_i, // Decoded value, whole units
	output logic match_o                         // High on match
);

	// ==========================================================
	// Scale and truncate the decoded value to the bus format
	wire logic is_frac;
	wire logic [VAL_W-1:0] scaled;
	wire logic [DATA_W-1:0] cmp_value;
	wire logic match_comb;
	logic match_ff;
	logic nxt_match;

	assign is_frac = (fmt_i == FMT_SFRAC);
	// Integer formats have no fraction bits, so the whole bus is integer bits
	assign scaled = is_frac ? (value_i <<< DEC_FRAC_W) : value_i;
	assign cmp_value = scaled[DATA_W-1:0];
	// Equality over all bits covers the sign bit of signed formats
	assign match_comb = (data_i == cmp_value);

	// ==========================================================
	// Output register
	assign nxt_match = rstn_i ? match_comb : RST_BIT;

	always_ff @(posedge mclk_i)
	begin
		match_ff <= nxt_match;
	end

	assign match_o = reg_en_i ? match_ff : match_comb;

endmodule : value_decoder
